// ===== hdl/output_conditioning_pkg.sv
// constants and carriers for the output conditioning configuration block
// assumes one 100 MHz clock and a 24-bit word-addressed configuration store
package output_conditioning_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 24;
   localparam int SAMPLE_W = 12;
   localparam int FRAC_W = 7;
   localparam int SEG_W = 5;
   localparam int COEF_NUM = 33;
   localparam int SLEW_W = 3;

   // ----------------------------------------------------------------
   // word offsets of the store
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] COEF_FIRST_ADDR = 8'h0B;
   localparam logic [ADDR_W-1:0] SHAPE_CTRL_ADDR = 8'h1B;
   localparam logic [ADDR_W-1:0] SUPPLY_CTRL_ADDR = 8'h1C;
   localparam logic [ADDR_W-1:0] DRIVER_CTRL_ADDR = 8'h1E;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int COEF_HI_LSB = 12;
   localparam int SHAPE_LOADED_POS = 23;
   localparam int POLARITY_POS = 22;
   localparam int UVD_OFF_POS = 9;
   localparam int SLEW_LSB = 18;
   localparam logic [SAMPLE_W-1:0] COEF_RESET = 12'h000;
   localparam logic [DATA_W-1:0] RDATA_RESET = 24'h000000;

   typedef struct packed {
      logic shapingLoaded;
      logic polarityFlip;
      logic uvdOff;
      logic [SLEW_W-1:0] slew;
   } cfg_s;

   localparam cfg_s CFG_RESET = '{shapingLoaded: 1'b0, polarityFlip: 1'b0, uvdOff: 1'b0,
                                  slew: 3'h0};

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } busReq_s;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_LOAD = 1'b1
   } load_e;

endpackage

// ===== hdl/segment_interp.sv
// straight-line interpolation between two neighbouring segment coefficients
// assumes unsigned 12-bit coefficients and a 7-bit position inside the segment
`timescale 1ns/1ps
`default_nettype none

module segment_interp
   import output_conditioning_pkg::*;
(
   input wire logic [SAMPLE_W-1:0] lowCoef,
   input wire logic [SAMPLE_W-1:0] highCoef,
   input wire logic [FRAC_W-1:0] frac,
   output logic [SAMPLE_W-1:0] shaped
);

   logic signed [13:0] diff;
   logic signed [21:0] prod;
   logic signed [14:0] sum;

   // ----------------------------------------------------------------
   // interpolation
   // ----------------------------------------------------------------
   // result always lies between the two end points, so no clamp is needed
   always_comb
   begin
      diff = $signed({2'b00, highCoef}) - $signed({2'b00, lowCoef});
      prod = diff * $signed({1'b0, frac});
      sum = $signed({3'b000, lowCoef}) + $signed(prod[21:7]);
      shaped = sum[SAMPLE_W-1:0];
   end

endmodule

`default_nettype wire

// ===== hdl/output_conditioning_config.sv
// configuration store and output conditioning path of a linear field sensor
// assumes synchronous inputs on clk and a programmer on the plain register port
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - With the shaping-loaded flag set, the stored segment coefficients shape every sample.
// - With the flag clear, its default, samples pass the shaping stage unchanged.
// - The undervoltage-detect-off bit leaves detection on at 0, its default, and off at 1.
// - With the polarity bit at 0 the output value is the value from the shaping stage, unchanged.
// - With the polarity bit at 1 the output value is mirrored about mid-scale, full scale minus the value.
// - A 3-bit slew code picks one of eight driver ramps, 000 the default and fastest.
module output_conditioning_config
   import output_conditioning_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdata,
   input wire logic [SAMPLE_W-1:0] sampleIn,
   input wire logic sampleValid,
   input wire logic lowVoltageIn,
   input wire logic reloadReq,
   output logic [SAMPLE_W-1:0] outValue,
   output logic outValid,
   output logic [SLEW_W-1:0] driverSlew,
   output logic undervoltageDetectEn,
   output logic lowVoltageFault,
   output logic configBusy
);

   busReq_s req;
   cfg_s storeCfg;
   cfg_s next_storeCfg;
   cfg_s activeCfg;
   cfg_s next_activeCfg;
   load_e loadState;
   load_e next_loadState;
   logic [SAMPLE_W-1:0] shaping_coefficient_table [0:COEF_NUM-1];
   logic [SAMPLE_W-1:0] next_coefTable [0:COEF_NUM-1];
   logic [DATA_W-1:0] next_regRdata;
   logic [SAMPLE_W-1:0] next_outValue;
   logic next_outValid;
   logic next_lowVoltageFault;
   logic [ADDR_W-1:0] coefWord;
   logic [5:0] coefIdx;
   logic inCoefRange;
   logic [SEG_W-1:0] seg;
   logic [SAMPLE_W-1:0] interpOut;
   logic [SAMPLE_W-1:0] shaped;

   assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
   assign coefWord = req.addr - COEF_FIRST_ADDR;
   assign coefIdx = {coefWord[4:0], 1'b0};
   assign inCoefRange = (req.addr >= COEF_FIRST_ADDR) && (req.addr <= SHAPE_CTRL_ADDR);
   assign seg = sampleIn[SAMPLE_W-1:FRAC_W];

   // ----------------------------------------------------------------
   // configuration store
   // ----------------------------------------------------------------
   // the store models the nonvolatile image; the output path reads its coefficients directly and its settings only through the load
   always_comb
   begin
      next_coefTable = shaping_coefficient_table;
      next_storeCfg = storeCfg;
      if (req.wr)
      begin
         if (inCoefRange)
         begin
            next_coefTable[coefIdx] = req.wdata[SAMPLE_W-1:0];
            if (req.addr != SHAPE_CTRL_ADDR)
            begin
               next_coefTable[coefIdx + 6'd1] = req.wdata[DATA_W-1:COEF_HI_LSB];
            end
         end
         unique case (req.addr)
            SHAPE_CTRL_ADDR:
            begin
               next_storeCfg.shapingLoaded = req.wdata[SHAPE_LOADED_POS];
               next_storeCfg.polarityFlip = req.wdata[POLARITY_POS];
            end
            SUPPLY_CTRL_ADDR:
            begin
               next_storeCfg.uvdOff = req.wdata[UVD_OFF_POS];
            end
            DRIVER_CTRL_ADDR:
            begin
               next_storeCfg.slew = req.wdata[SLEW_LSB +: SLEW_W];
            end
            default:
            begin
               next_storeCfg = storeCfg;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         storeCfg <= CFG_RESET;
         for (int i = 0; i < COEF_NUM; i++)
         begin
            shaping_coefficient_table[i] <= COEF_RESET;
         end
      end
      else if (ce)
      begin
         storeCfg <= next_storeCfg;
         shaping_coefficient_table <= next_coefTable;
      end
   end

   // ----------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------
   always_comb
   begin
      next_regRdata = RDATA_RESET;
      if (req.rd)
      begin
         if (inCoefRange && (req.addr != SHAPE_CTRL_ADDR))
         begin
            next_regRdata = {shaping_coefficient_table[coefIdx + 6'd1],
                             shaping_coefficient_table[coefIdx]};
         end
         else if (req.addr == SHAPE_CTRL_ADDR)
         begin
            next_regRdata[SAMPLE_W-1:0] = shaping_coefficient_table[COEF_NUM-1];
            next_regRdata[SHAPE_LOADED_POS] = storeCfg.shapingLoaded;
            next_regRdata[POLARITY_POS] = storeCfg.polarityFlip;
         end
         else if (req.addr == SUPPLY_CTRL_ADDR)
         begin
            next_regRdata[UVD_OFF_POS] = storeCfg.uvdOff;
         end
         else if (req.addr == DRIVER_CTRL_ADDR)
         begin
            next_regRdata[SLEW_LSB +: SLEW_W] = storeCfg.slew;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         regRdata <= RDATA_RESET;
      end
      else if (ce)
      begin
         regRdata <= next_regRdata;
      end
   end

   // ----------------------------------------------------------------
   // power-up load of the active settings
   // ----------------------------------------------------------------
   // settings change only in the load cycle, so the output never sees a half-written word
   always_comb
   begin
      next_activeCfg = activeCfg;
      next_loadState = loadState;
      unique case (loadState)
         ST_LOAD:
         begin
            next_activeCfg = storeCfg;
            next_loadState = ST_IDLE;
         end
         ST_IDLE:
         begin
            if (reloadReq)
            begin
               next_loadState = ST_LOAD;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         activeCfg <= CFG_RESET;
         loadState <= ST_LOAD;
      end
      else if (ce)
      begin
         activeCfg <= next_activeCfg;
         loadState <= next_loadState;
      end
   end

   // ----------------------------------------------------------------
   // output path
   // ----------------------------------------------------------------
   segment_interp shaper
   (
      .lowCoef(shaping_coefficient_table[seg]),
      .highCoef(shaping_coefficient_table[{1'b0, seg} + 6'd1]),
      .frac(sampleIn[FRAC_W-1:0]),
      .shaped(interpOut)
   );

   // coefficients are read live; the flag guards against a partly written table
   assign shaped = activeCfg.shapingLoaded ? interpOut : sampleIn;

   always_comb
   begin
      next_outValue = outValue;
      next_outValid = sampleValid;
      if (sampleValid)
      begin
         next_outValue = activeCfg.polarityFlip ? ~shaped : shaped;
      end
      next_lowVoltageFault = lowVoltageIn && !activeCfg.uvdOff;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         outValue <= COEF_RESET;
         outValid <= 1'b0;
         lowVoltageFault <= 1'b0;
         driverSlew <= CFG_RESET.slew;
         undervoltageDetectEn <= 1'b1;
         configBusy <= 1'b1;
      end
      else if (ce)
      begin
         outValue <= next_outValue;
         outValid <= next_outValid;
         lowVoltageFault <= next_lowVoltageFault;
         driverSlew <= next_activeCfg.slew;
         undervoltageDetectEn <= !next_activeCfg.uvdOff;
         configBusy <= (next_loadState == ST_LOAD);
      end
   end

endmodule

`default_nettype wire

// ===== verification/output_conditioning_monitor.sv
// port checker for the output conditioning block
// bound to the block; one clock domain, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module output_conditioning_monitor
   import output_conditioning_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [DATA_W-1:0] regRdata,
   input wire logic [SAMPLE_W-1:0] sampleIn,
   input wire logic sampleValid,
   input wire logic lowVoltageIn,
   input wire logic reloadReq,
   input wire logic [SAMPLE_W-1:0] outValue,
   input wire logic outValid,
   input wire logic [SLEW_W-1:0] driverSlew,
   input wire logic undervoltageDetectEn,
   input wire logic lowVoltageFault,
   input wire logic configBusy
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   property p_vld; ce && sampleValid |=> outValid; endproperty
   a_vld: assert property (p_vld) else $error("no strobe after sample");
   // a frozen edge keeps the old strobe, so only judge edges that really clocked
   property p_one; $past(ce) && outValid |-> $past(sampleValid); endproperty
   a_one: assert property (p_one) else $error("stray output strobe");
   property p_bsy; ce && configBusy |=> !configBusy; endproperty
   a_bsy: assert property (p_bsy) else $error("load longer than one cycle");
   property p_rld; ce && reloadReq && !configBusy |=> configBusy; endproperty
   a_rld: assert property (p_rld) else $error("reload not started");
   // settings may move only in the cycle after a load
   property p_hold; !$past(configBusy) |-> $stable(driverSlew) && $stable(undervoltageDetectEn);
   endproperty
   a_hold: assert property (p_hold) else $error("settings moved");
   property p_lvf;
      $past(ce) |-> lowVoltageFault == ($past(lowVoltageIn) && $past(undervoltageDetectEn));
   endproperty
   a_lvf: assert property (p_lvf) else $error("fault not gated by detect enable");
   property p_slw;
      ce && regRd && regAddr == DRIVER_CTRL_ADDR |=> regRdata[23:21] == 0 && regRdata[17:0] == 0;
   endproperty
   a_slw: assert property (p_slw) else $error("slew word spare bits set");
   c_smp: cover property (sampleValid);
   c_rld: cover property (reloadReq && !configBusy);
   c_lvf: cover property (lowVoltageFault);
endmodule
bind output_conditioning_config output_conditioning_monitor i_mon (.clk(clk),
   .reset_n(reset_n), .ce(ce), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
   .regRd(regRd), .regRdata(regRdata), .sampleIn(sampleIn), .sampleValid(sampleValid),
   .lowVoltageIn(lowVoltageIn), .reloadReq(reloadReq), .outValue(outValue),
   .outValid(outValid), .driverSlew(driverSlew), .undervoltageDetectEn(undervoltageDetectEn),
   .lowVoltageFault(lowVoltageFault), .configBusy(configBusy));
`default_nettype wire

// ===== verification/coef_programmer.sv
// programmer model: coefficient words first, control word last
// assumes the bench routes req onto the register port while req.wr is high
`timescale 1ns/1ps
`default_nettype none
module coef_programmer
   import output_conditioning_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic go,
   input wire logic [1:0] ctrlBits,
   output busReq_s req,
   output logic busy
);
   logic [4:0] idx;
   // dips every third point so the slope goes negative too
   function automatic logic [11:0] cf(input int i);
      return 12'(i * 120 + (i % 3) * 200);
   endfunction
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
      begin
         busy <= 1'b0;
         idx <= 5'h00;
         req <= '0;
      end
      else if (busy && idx < 5'h11)
      begin
         // flag word only after every coefficient word
         req <= '{addr: COEF_FIRST_ADDR + 8'(idx), wdata: (idx == 5'h10) ?
            {ctrlBits, 10'h000, cf(32)} : {cf(2 * idx + 1), cf(2 * idx)}, wr: 1'b1, rd: 1'b0};
         idx <= idx + 5'h01;
      end
      else
      begin
         // released bus toggles so no stale value can pass for data
         busy <= go;
         idx <= 5'h00;
         req <= '{addr: ~req.addr, wdata: ~req.wdata, wr: 1'b0, rd: 1'b0};
      end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the output conditioning block
// assumes the package, design and programmer model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import output_conditioning_pkg::*;
;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic ce = 1'b1;
   logic detOn = 1'b1;
   logic [11:0] lastExp = 12'h000;
   int w = 0;
   logic go = 1'b0;
   logic [1:0] mode = 2'b00;
   logic sampleValid = 1'b0;
   logic lowVoltageIn = 1'b0;
   logic reloadReq = 1'b0;
   logic [11:0] sampleIn = 12'h000;
   logic [31:0] rnd = 32'h4EFAB0A8;
   busReq_s tbReq = '0;
   busReq_s progReq;
   busReq_s req;
   logic busy, outValid, detectEn, fault, configBusy;
   logic [23:0] rdata;
   logic [11:0] outValue;
   logic [2:0] driverSlew;
   logic [7:0] cfgAddr [3] = '{SHAPE_CTRL_ADDR, SUPPLY_CTRL_ADDR, DRIVER_CTRL_ADDR};
   logic [1:0] modes [3] = '{2'b10, 2'b11, 2'b01};
   int fails = 0;
   int n_tests = 0;
   always #5 clk = ~clk;
   assign req = progReq.wr ? progReq : tbReq;
   coef_programmer i_prog (.clk(clk), .reset_n(reset_n), .go(go), .ctrlBits(mode),
      .req(progReq), .busy(busy));
   output_conditioning_config i_dut (.clk(clk), .reset_n(reset_n), .ce(ce),
      .regAddr(req.addr), .regWdata(req.wdata), .regWr(req.wr), .regRd(req.rd),
      .regRdata(rdata), .sampleIn(sampleIn), .sampleValid(sampleValid),
      .lowVoltageIn(lowVoltageIn), .reloadReq(reloadReq), .outValue(outValue),
      .outValid(outValid), .driverSlew(driverSlew), .undervoltageDetectEn(detectEn),
      .lowVoltageFault(fault), .configBusy(configBusy));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic int cf(input int i);
      return (i * 120 + (i % 3) * 200) % 4096;
   endfunction
   function automatic logic [11:0] expOut(input logic [11:0] s, input logic [1:0] m);
      int lo;
      int v;
      lo = cf(int'(s[11:7]));
      v = m[1] ? lo + (((cf(int'(s[11:7]) + 1) - lo) * int'(s[6:0])) >>> 7) : int'(s);
      return m[0] ? 12'hFFF - 12'(v) : 12'(v);
   endfunction
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rw(input logic w, input logic [7:0] a, input logic [23:0] d);
      @(posedge clk);
      tbReq <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk);
      tbReq <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
      #1;
   endtask
   task automatic sample(input logic [11:0] s);
      logic lv;
      lv = rnd[3];
      @(posedge clk);
      sampleValid <= 1'b1;
      sampleIn <= s;
      lowVoltageIn <= lv;
      @(posedge clk);
      sampleValid <= 1'b0;
      #1;
      lastExp = expOut(s, mode);
      check("outValue", expOut(s, mode), outValue);
      check("outValid", 24'h1, {23'h0, outValid});
      check("lowVoltageFault", {23'h0, lv && detOn}, {23'h0, fault});
   endtask
   // a sample offered while ce is low must leave outValue and outValid as they were
   task automatic freeze();
      @(posedge clk);
      ce <= 1'b0;
      sampleValid <= 1'b1;
      sampleIn <= ~lastExp;
      @(posedge clk);
      ce <= 1'b1;
      sampleValid <= 1'b0;
      #1;
      check("frozenValue", {12'h0, lastExp}, {12'h0, outValue});
      check("frozenValid", 24'h0, {23'h0, outValid});
   endtask
   task automatic reload();
      @(posedge clk);
      reloadReq <= 1'b1;
      @(posedge clk);
      reloadReq <= 1'b0;
      @(posedge clk);
      #1;
      check("configBusy", 24'h0, {23'h0, configBusy});
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      #1;
      check("detectEn", 24'h1, {23'h0, detectEn});
      foreach (cfgAddr[i])
      begin
         rw(1'b0, cfgAddr[i], 24'h0);
         check("cfgReset", 24'h0, rdata);
      end
      repeat (20)
      begin
         rnd = lfsr(rnd);
         sample(rnd[11:0]);
      end
      freeze();
      for (int k = 0; k < 8; k++)
      begin
         rw(1'b1, DRIVER_CTRL_ADDR, 24'(k) << SLEW_LSB);
         rw(1'b1, SUPPLY_CTRL_ADDR, 24'(k & 1) << UVD_OFF_POS);
         rw(1'b0, DRIVER_CTRL_ADDR, 24'h0);
         check("slewRead", 24'(k) << SLEW_LSB, rdata);
         check("slewHeld", 24'(k > 0 ? k - 1 : 0), {21'h0, driverSlew});
         reload();
         detOn = !(k & 1);
         check("slew", 24'(k), {21'h0, driverSlew});
         check("detectEn", 24'(~k & 1), {23'h0, detectEn});
      end
      rw(1'b1, 8'h20, 24'hFFFFFF);
      rw(1'b0, 8'h20, 24'h0);
      check("unmapped", 24'h0, rdata);
      foreach (modes[i])
      begin
         mode <= modes[i];
         @(posedge clk);
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         repeat (3) @(posedge clk);
         for (int t = 0; t < 40 && busy; t++) @(posedge clk);
         rnd = lfsr(rnd);
         w = int'(rnd[3:0]);
         rw(1'b0, COEF_FIRST_ADDR + 8'(w), 24'h0);
         check("coefRead", {12'(cf(2 * w + 1)), 12'(cf(2 * w))}, rdata);
         rw(1'b0, SHAPE_CTRL_ADDR, 24'h0);
         check("flagRead", {modes[i], 10'h000, 12'(cf(32))}, rdata);
         reload();
         sample(12'h000);
         sample(12'hFFF);
         repeat (20)
         begin
            rnd = lfsr(rnd);
            sample(rnd[11:0]);
         end
      end
      stop_test();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      stop_test();
   end
endmodule
`default_nettype wire
